// ### shared/cbd_consts.vh
`ifndef CBD_CONSTS_VH
`define CBD_CONSTS_VH

// ----------------------------------------------------------------
// bus cycle codes
// ----------------------------------------------------------------
`define CBD_CODE_W 3
`define CBD_CODE_FREE 3'h0
`define CBD_CODE_PFETCH 3'h1
`define CBD_CODE_OPRD 3'h2
`define CBD_CODE_OPWR 3'h3
`define CBD_CODE_PUSH 3'h4
`define CBD_CODE_POP 3'h5
`define CBD_CODE_VECT 3'h6

// ----------------------------------------------------------------
// addressing modes
// ----------------------------------------------------------------
`define CBD_MODE_W 4
`define CBD_MODE_ABS 4'h0
`define CBD_MODE_IX 4'h1
`define CBD_MODE_IX1 4'h2
`define CBD_MODE_IX2 4'h3
`define CBD_MODE_IXP 4'h4
`define CBD_MODE_IX1P 4'h5
`define CBD_MODE_SP1 4'h6
`define CBD_MODE_SP2 4'h7
`define CBD_MODE_REL 4'h8

// ----------------------------------------------------------------
// condition flag positions and per-flag actions
// ----------------------------------------------------------------
`define CBD_FLAG_C 0
`define CBD_FLAG_Z 1
`define CBD_FLAG_N 2
`define CBD_FLAG_I 3
`define CBD_FLAG_H 4
`define CBD_FLAG_V 5
`define CBD_NFLAGS 6
`define CBD_FACT_KEEP 2'h0
`define CBD_FACT_CLR 2'h1
`define CBD_FACT_SET 2'h2
`define CBD_FACT_UNDEF 2'h3

// ----------------------------------------------------------------
// constants and reset values
// ----------------------------------------------------------------
`define CBD_PAGE2_PREFIX 8'h9e
`define CBD_VECTOR_PAGE 8'hff
`define CBD_SEQ_DEPTH 16
`define CBD_SEQ_AW 4
`define CBD_RST_FLAGS 6'h08
`define CBD_RST_PC 16'h0000
`define CBD_RST_SP 16'h00ff
`define CBD_RST_INDEX 16'h0000

`endif

// ### hw/cbd_code_mem.v
`timescale 1ns/100ps
`include "cbd_consts.vh"

module cbd_code_mem (
    // clock
    input wire clock_i,
    // write port
    input wire wr_en_i,
    input wire [`CBD_SEQ_AW-1:0] wr_addr_i,
    input wire [`CBD_CODE_W-1:0] wr_data_i,
    // read port
    input wire [`CBD_SEQ_AW-1:0] rd_addr_i,
    output reg [`CBD_CODE_W-1:0] rd_data_o
);

    reg [`CBD_CODE_W-1:0] mem [0:`CBD_SEQ_DEPTH-1];

    always @(posedge clock_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end

endmodule

// ### hw/cbd_cycle_seq.v
//
// Overview of operation
// - free cycle: one clock, read, no bus request
// - program fetch reads at counter, counter advances
// - operand read brings one byte in
// - operand write sends one byte out
// - push writes one stack byte; pop reads one
// - vector read from top page, high byte first
// - six condition flags, each set/clear/keep/undefined
// - index and counter built from high:low bytes
// - indexed address: none, 8-bit or 16-bit offset
// - post-increment modes bump index after access
// - stack-relative address: 8 or 16-bit offset
// - relative target within -128..+127 of next
// - opcode after prefix 9e decodes second page
//
`timescale 1ns/100ps
`include "cbd_consts.vh"

module cbd_cycle_seq (
    // clock and reset
    input wire clock_i,
    input wire rst_n_i,
    // cycle code list loading and start
    input wire code_wr_i,
    input wire [`CBD_SEQ_AW-1:0] code_addr_i,
    input wire [`CBD_CODE_W-1:0] code_i,
    input wire [`CBD_SEQ_AW-1:0] code_last_i,
    input wire start_i,
    // operand and addressing
    input wire [`CBD_MODE_W-1:0] mode_i,
    input wire [15:0] offset_i,
    input wire [7:0] vec_low_i,
    input wire [7:0] wdata_i,
    // register loads from the core
    input wire index_load_i,
    input wire [7:0] index_high_i,
    input wire [7:0] index_low_i,
    input wire pc_load_i,
    input wire [7:0] program_counter_high_i,
    input wire [7:0] program_counter_low_i,
    input wire sp_load_i,
    input wire [15:0] stack_pointer_i,
    input wire branch_i,
    // condition flag updates
    input wire flag_upd_i,
    input wire [2*`CBD_NFLAGS-1:0] flag_act_i,
    input wire [`CBD_NFLAGS-1:0] flag_val_i,
    // system bus
    output reg [15:0] bus_addr_o,
    output reg [7:0] bus_wdata_o,
    output reg bus_rd_o,
    output reg bus_wr_o,
    output reg bus_req_o,
    input wire [7:0] bus_rdata_i,
    // status to the core
    output wire busy_o,
    output reg done_o,
    output reg [`CBD_CODE_W-1:0] code_o,
    output reg [7:0] rdata_o,
    output reg [7:0] fetch_o,
    output reg fetch_valid_o,
    output reg page2_o,
    output wire [15:0] program_counter_o,
    output reg [15:0] stack_pointer_o,
    output wire [15:0] index_o,
    output reg [15:0] ea_o,
    output reg [`CBD_NFLAGS-1:0] condition_flags_reg_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    localparam ST_IDLE = 2'h0;
    localparam ST_PRIME = 2'h1;
    localparam ST_RUN = 2'h2;
    localparam [15:0] RST_PC = `CBD_RST_PC;
    localparam [15:0] RST_INDEX = `CBD_RST_INDEX;
    localparam [`CBD_NFLAGS-1:0] RST_FLAGS = `CBD_RST_FLAGS;

    reg [1:0] state;
    reg [`CBD_SEQ_AW-1:0] step;
    reg [`CBD_SEQ_AW-1:0] last;
    reg [7:0] program_counter_high;
    reg [7:0] program_counter_low;
    reg [7:0] index_high;
    reg [7:0] index_low;
    reg vec_second;
    reg prefix_seen;
    reg [`CBD_CODE_W-1:0] bus_code;
    reg [`CBD_SEQ_AW-1:0] rd_addr;
    wire [`CBD_CODE_W-1:0] cur_code;
    wire [15:0] program_counter;
    wire [15:0] index_value;
    wire [15:0] ea_now;

    assign program_counter = {program_counter_high, program_counter_low};
    assign index_value = {index_high, index_low};
    assign program_counter_o = program_counter;
    assign index_o = index_value;
    assign busy_o = (state != ST_IDLE);

    // ------------------------------------------------------------
    // effective address decode
    // ------------------------------------------------------------
    function [15:0] cbd_ea;
        input [`CBD_MODE_W-1:0] mode;
        input [15:0] idx;
        input [15:0] sp;
        input [15:0] pc;
        input [15:0] off;
        begin
            case (mode)
                `CBD_MODE_IX, `CBD_MODE_IXP: cbd_ea = idx;
                `CBD_MODE_IX1, `CBD_MODE_IX1P: cbd_ea = idx + {8'h00, off[7:0]};
                `CBD_MODE_IX2: cbd_ea = idx + off;
                `CBD_MODE_SP1: cbd_ea = sp + {8'h00, off[7:0]};
                `CBD_MODE_SP2: cbd_ea = sp + off;
                // signed byte reaches -128..+127 around the next instruction
                `CBD_MODE_REL: cbd_ea = pc + {{8{off[7]}}, off[7:0]};
                default: cbd_ea = off;
            endcase
        end
    endfunction

    function is_post_inc;
        input [`CBD_MODE_W-1:0] mode;
        begin
            is_post_inc = (mode == `CBD_MODE_IXP) || (mode == `CBD_MODE_IX1P);
        end
    endfunction

    assign ea_now = cbd_ea(mode_i, index_value, stack_pointer_o, program_counter, offset_i);

    // ------------------------------------------------------------
    // code list memory
    // ------------------------------------------------------------
    always @* begin
        if (state == ST_RUN) begin
            rd_addr = step + 4'h1;
        end else begin
            rd_addr = {`CBD_SEQ_AW{1'b0}};
        end
    end

    cbd_code_mem u_code_mem (
        .clock_i(clock_i),
        .wr_en_i(code_wr_i),
        .wr_addr_i(code_addr_i),
        .wr_data_i(code_i),
        .rd_addr_i(rd_addr),
        .rd_data_o(cur_code)
    );

    // ------------------------------------------------------------
    // sequencer and bus cycles
    // ------------------------------------------------------------
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            state <= ST_IDLE;
            step <= {`CBD_SEQ_AW{1'b0}};
            last <= {`CBD_SEQ_AW{1'b0}};
            program_counter_high <= RST_PC[15:8];
            program_counter_low <= RST_PC[7:0];
            index_high <= RST_INDEX[15:8];
            index_low <= RST_INDEX[7:0];
            stack_pointer_o <= `CBD_RST_SP;
            vec_second <= 1'b0;
            prefix_seen <= 1'b0;
            bus_code <= `CBD_CODE_FREE;
            bus_addr_o <= 16'h0000;
            bus_wdata_o <= 8'h00;
            bus_rd_o <= 1'b0;
            bus_wr_o <= 1'b0;
            bus_req_o <= 1'b0;
            done_o <= 1'b0;
            code_o <= `CBD_CODE_FREE;
            rdata_o <= 8'h00;
            fetch_o <= 8'h00;
            fetch_valid_o <= 1'b0;
            page2_o <= 1'b0;
            ea_o <= 16'h0000;
        end else begin
            bus_rd_o <= 1'b0;
            bus_wr_o <= 1'b0;
            bus_req_o <= 1'b0;
            done_o <= 1'b0;
            fetch_valid_o <= 1'b0;
            // capture of the read that stood on the bus this cycle
            if (bus_rd_o && bus_req_o) begin
                case (bus_code)
                    `CBD_CODE_PFETCH: begin
                        fetch_o <= bus_rdata_i;
                        fetch_valid_o <= 1'b1;
                        page2_o <= prefix_seen;
                        prefix_seen <= (bus_rdata_i == `CBD_PAGE2_PREFIX) && !prefix_seen;
                    end
                    `CBD_CODE_OPRD, `CBD_CODE_POP: begin
                        rdata_o <= bus_rdata_i;
                    end
                    `CBD_CODE_VECT: begin
                        if (bus_addr_o[0] == vec_low_i[0]) begin
                            program_counter_high <= bus_rdata_i;
                        end else begin
                            program_counter_low <= bus_rdata_i;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            if (pc_load_i) begin
                program_counter_high <= program_counter_high_i;
                program_counter_low <= program_counter_low_i;
            end else if (branch_i) begin
                {program_counter_high, program_counter_low} <= cbd_ea(`CBD_MODE_REL,
                    index_value, stack_pointer_o, program_counter, offset_i);
            end
            if (index_load_i) begin
                index_high <= index_high_i;
                index_low <= index_low_i;
            end
            if (sp_load_i) begin
                stack_pointer_o <= stack_pointer_i;
            end
            case (state)
                ST_IDLE: begin
                    if (start_i) begin
                        state <= ST_PRIME;
                        last <= code_last_i;
                        vec_second <= 1'b0;
                    end
                end
                ST_PRIME: begin
                    state <= ST_RUN;
                    step <= {`CBD_SEQ_AW{1'b0}};
                end
                ST_RUN: begin
                    code_o <= cur_code;
                    bus_code <= cur_code;
                    case (cur_code)
                        `CBD_CODE_PFETCH: begin
                            bus_addr_o <= program_counter;
                            bus_rd_o <= 1'b1;
                            bus_req_o <= 1'b1;
                            if (!pc_load_i && !branch_i) begin
                                {program_counter_high, program_counter_low} <=
                                    program_counter + 16'h0001;
                            end
                        end
                        `CBD_CODE_OPRD, `CBD_CODE_OPWR: begin
                            bus_addr_o <= ea_now;
                            ea_o <= ea_now;
                            bus_req_o <= 1'b1;
                            bus_rd_o <= (cur_code == `CBD_CODE_OPRD);
                            bus_wr_o <= (cur_code == `CBD_CODE_OPWR);
                            bus_wdata_o <= wdata_i;
                            if (is_post_inc(mode_i) && !index_load_i) begin
                                {index_high, index_low} <= index_value + 16'h0001;
                            end
                        end
                        `CBD_CODE_PUSH: begin
                            bus_addr_o <= stack_pointer_o;
                            bus_wdata_o <= wdata_i;
                            bus_wr_o <= 1'b1;
                            bus_req_o <= 1'b1;
                            if (!sp_load_i) begin
                                stack_pointer_o <= stack_pointer_o - 16'h0001;
                            end
                        end
                        `CBD_CODE_POP: begin
                            bus_addr_o <= stack_pointer_o + 16'h0001;
                            bus_rd_o <= 1'b1;
                            bus_req_o <= 1'b1;
                            if (!sp_load_i) begin
                                stack_pointer_o <= stack_pointer_o + 16'h0001;
                            end
                        end
                        `CBD_CODE_VECT: begin
                            // first vector cycle takes the high byte
                            bus_addr_o <= {`CBD_VECTOR_PAGE, vec_low_i[7:1],
                                vec_second ^ vec_low_i[0]};
                            bus_rd_o <= 1'b1;
                            bus_req_o <= 1'b1;
                            vec_second <= ~vec_second;
                        end
                        default: begin
                            // free cycle: a read with no request
                            bus_addr_o <= program_counter;
                            bus_rd_o <= 1'b1;
                        end
                    endcase
                    if (step == last) begin
                        state <= ST_IDLE;
                        done_o <= 1'b1;
                    end else begin
                        step <= step + 4'h1;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // condition flags
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `CBD_NFLAGS; gi = gi + 1) begin : g_flag
            always @(posedge clock_i) begin
                if (!rst_n_i) begin
                    condition_flags_reg_o[gi] <= RST_FLAGS[gi];
                end else if (flag_upd_i) begin
                    case (flag_act_i[2*gi+1:2*gi])
                        `CBD_FACT_CLR: condition_flags_reg_o[gi] <= 1'b0;
                        `CBD_FACT_SET: condition_flags_reg_o[gi] <= flag_val_i[gi];
                        default: condition_flags_reg_o[gi] <= condition_flags_reg_o[gi];
                    endcase
                end
            end
        end
    endgenerate

endmodule

// ### testbench/cbd_cycle_seq_asserts.sv
`timescale 1ns/100ps
`include "cbd_consts.vh"

module cbd_cycle_seq_asserts (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // watched inputs
    input wire logic [7:0] wdata_i,
    input wire logic [7:0] bus_rdata_i,
    // watched outputs
    input wire logic [15:0] bus_addr_o,
    input wire logic [7:0] bus_wdata_o,
    input wire logic bus_rd_o,
    input wire logic bus_wr_o,
    input wire logic bus_req_o,
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic [`CBD_CODE_W-1:0] code_o,
    input wire logic [7:0] rdata_o,
    input wire logic [7:0] fetch_o,
    input wire logic fetch_valid_o,
    input wire logic [15:0] program_counter_o,
    input wire logic [15:0] stack_pointer_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    wire logic acc = bus_rd_o || bus_wr_o;

    a_free_no_req: assert property (
        bus_rd_o && code_o == `CBD_CODE_FREE |-> !bus_req_o && !bus_wr_o)
        else $error("free cycle used the bus");
    a_fetch_advance: assert property (
        bus_rd_o && code_o == `CBD_CODE_PFETCH |-> program_counter_o == bus_addr_o + 16'h1)
        else $error("counter not past fetch address");
    a_fetch_capture: assert property (
        bus_rd_o && code_o == `CBD_CODE_PFETCH |=> fetch_valid_o && fetch_o == $past(bus_rdata_i))
        else $error("fetched byte lost");
    a_read_capture: assert property (
        bus_rd_o && (code_o == `CBD_CODE_OPRD || code_o == `CBD_CODE_POP)
        |=> rdata_o == $past(bus_rdata_i))
        else $error("read byte lost");
    a_write_data: assert property (
        bus_wr_o |-> !bus_rd_o && bus_wdata_o == $past(wdata_i)
        && (code_o == `CBD_CODE_OPWR || code_o == `CBD_CODE_PUSH))
        else $error("bad write cycle");
    a_push_order: assert property (
        bus_wr_o && code_o == `CBD_CODE_PUSH |-> stack_pointer_o == bus_addr_o - 16'h1)
        else $error("push not at stack pointer");
    a_pop_order: assert property (
        bus_rd_o && code_o == `CBD_CODE_POP |-> stack_pointer_o == bus_addr_o)
        else $error("pop not after increment");
    a_vector_page: assert property (
        bus_rd_o && code_o == `CBD_CODE_VECT |-> bus_req_o && bus_addr_o[15:8] == `CBD_VECTOR_PAGE)
        else $error("vector outside top page");
    a_start_lead: assert property ($rose(busy_o) |-> ##[1:3] acc)
        else $error("first code late");
    a_back_to_back: assert property (acc && !done_o |=> acc)
        else $error("gap inside a sequence");
    a_done_last: assert property (done_o |-> acc ##1 !acc)
        else $error("done not on last code");

    c_vector: cover property (bus_rd_o && code_o == `CBD_CODE_VECT);
    c_push: cover property (bus_wr_o && code_o == `CBD_CODE_PUSH);
    c_done: cover property (done_o);
endmodule

bind cbd_cycle_seq cbd_cycle_seq_asserts i_cbd_cycle_seq_asserts (.*);

// ### testbench/cbd_bus_mem.sv
`timescale 1ns/100ps

module cbd_bus_mem (
    // clock
    input wire logic clock_i,
    // bus from the sequencer
    input wire logic [15:0] addr_i,
    input wire logic rd_i,
    input wire logic req_i,
    input wire logic wr_i,
    input wire logic [7:0] wdata_i,
    // read data back
    output wire logic [7:0] rdata_o
);
    logic [7:0] mem [0:65535];
    logic [7:0] last = 8'h00;
    int i;
    // unwritten bytes hold a pattern of their address
    initial for (i = 0; i < 65536; i++) mem[i] = i[7:0] ^ 8'ha5;
    // released bus shows the inverse of the last byte driven
    assign rdata_o = (rd_i && req_i) ? mem[addr_i] : ~last;
    always @(posedge clock_i) begin
        if (wr_i) mem[addr_i] <= wdata_i;
        if (rd_i && req_i) last <= rdata_o;
    end
endmodule

// ### testbench/cbd_cycle_seq_tb.sv
`timescale 1ns/100ps
`include "cbd_consts.vh"

module cbd_cycle_seq_tb;
    logic clock_i = 0, rst_n_i = 0, code_wr_i = 0, start_i = 0, branch_i = 0, flag_upd_i = 0;
    logic index_load_i = 0, pc_load_i = 0, sp_load_i = 0;
    logic [3:0] code_addr_i = 0, code_last_i = 0, mode_i = 0;
    logic [2:0] code_i = 0;
    logic [15:0] offset_i = 0, stack_pointer_i = 0;
    logic [7:0] vec_low_i = 0, wdata_i = 0, index_high_i = 0, index_low_i = 0;
    logic [7:0] program_counter_high_i = 0, program_counter_low_i = 0;
    logic [11:0] flag_act_i = 0;
    logic [5:0] flag_val_i = 0;
    wire [15:0] bus_addr_o, program_counter_o, stack_pointer_o, index_o, ea_o;
    wire [7:0] bus_wdata_o, bus_rdata_i, rdata_o, fetch_o;
    wire [2:0] code_o;
    wire [5:0] condition_flags_reg_o;
    wire bus_rd_o, bus_wr_o, bus_req_o, busy_o, done_o, fetch_valid_o, page2_o;
    int err_total = 0, n_compared = 0, cyc = 0;
    integer seed = 63554;
    logic [28:0] cap [$];
    logic [2:0] seq [16];

    cbd_cycle_seq i_cbd_cycle_seq (.*);
    cbd_bus_mem i_cbd_bus_mem (.clock_i(clock_i), .addr_i(bus_addr_o), .rd_i(bus_rd_o),
        .req_i(bus_req_o), .wr_i(bus_wr_o), .wdata_i(bus_wdata_o), .rdata_o(bus_rdata_i));

    always #5 clock_i = ~clock_i;

    // ----
    // bus cycle capture and hang limit
    // ----
    always @(posedge clock_i) begin
        if (bus_rd_o || bus_wr_o) cap.push_back({bus_req_o, bus_wr_o, code_o, bus_addr_o, bus_wdata_o});
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            print_verdict();
        end
    end

    task print_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function logic [7:0] pat(input logic [15:0] a);
        return a[7:0] ^ 8'ha5;
    endfunction

    function logic [15:0] ea(input logic [3:0] m, input logic [15:0] ix, sp, off);
        case (m)
            `CBD_MODE_ABS: ea = off;
            `CBD_MODE_IX, `CBD_MODE_IXP: ea = ix;
            `CBD_MODE_IX1, `CBD_MODE_IX1P: ea = ix + off[7:0];
            `CBD_MODE_IX2: ea = ix + off;
            `CBD_MODE_SP1: ea = sp + off[7:0];
            default: ea = sp + off;
        endcase
    endfunction

    function logic [5:0] nf(input logic [5:0] f, input logic [11:0] a, input logic [5:0] v);
        int i;
        nf = f;
        for (i = 0; i < 6; i++) begin
            if (a[2*i +: 2] == `CBD_FACT_CLR) nf[i] = 1'b0;
            else if (a[2*i +: 2] == `CBD_FACT_SET) nf[i] = v[i];
        end
    endfunction

    task ld(input logic [15:0] pc, ix, sp);
        @(posedge clock_i);
        {program_counter_high_i, program_counter_low_i} <= pc;
        {index_high_i, index_low_i} <= ix;
        stack_pointer_i <= sp;
        {pc_load_i, index_load_i, sp_load_i} <= 3'h7;
        @(posedge clock_i);
        {pc_load_i, index_load_i, sp_load_i} <= 3'h0;
    endtask

    task tick();
        @(posedge clock_i);
        {flag_upd_i, branch_i} <= 2'h0;
        @(posedge clock_i);
        #1;
    endtask

    task run(input int n);
        int k;
        for (k = 0; k < n; k++) begin
            @(posedge clock_i);
            code_wr_i <= 1'b1;
            code_addr_i <= k[3:0];
            code_i <= seq[k];
        end
        @(posedge clock_i);
        code_wr_i <= 1'b0;
        code_last_i <= n[3:0] - 4'h1;
        start_i <= 1'b1;
        cap.delete();
        @(posedge clock_i);
        start_i <= 1'b0;
        for (k = 0; k < 40 && done_o !== 1'b1; k++) @(posedge clock_i);
        @(posedge clock_i);
        #1;
        chk(cap.size(), n);
    endtask

    initial begin
        logic [15:0] pc, ix, sp, off, e;
        logic [11:0] act;
        logic [5:0] fl, val;
        logic [7:0] wd;
        int m, t;
        repeat (6) @(posedge clock_i);
        rst_n_i <= 1'b1;
        @(posedge clock_i);
        #1;
        chk(program_counter_o, `CBD_RST_PC);
        chk(stack_pointer_o, `CBD_RST_SP);
        chk(index_o, `CBD_RST_INDEX);
        chk(condition_flags_reg_o, `CBD_RST_FLAGS);
        $display("test reset done");
        for (m = 0; m < 9; m++) begin
            pc = $random(seed);
            ix = $random(seed);
            sp = $random(seed);
            off = m[0] ? 16'hffff : $random(seed);
            e = (m == 8) ? pc + 16'h1 + {{8{off[7]}}, off[7:0]} : ea(m[3:0], ix, sp, off);
            ld(pc, ix, sp);
            mode_i <= m[3:0];
            offset_i <= off;
            seq[0] = `CBD_CODE_PFETCH;
            seq[1] = `CBD_CODE_OPRD;
            run(2);
            chk(cap[0][23:8], pc);
            chk(program_counter_o, pc + 16'h1);
            chk(fetch_o, pat(pc));
            chk(cap[1][23:8], e);
            chk(ea_o, e);
            chk(rdata_o, pat(e));
            chk(index_o, ix + ((m == 4 || m == 5) ? 16'h1 : 16'h0));
        end
        $display("test modes done");
        t = $random(seed);
        wd = t[7:0];
        off = t[31:16];
        ld(pc, ix, 16'h0100);
        mode_i <= `CBD_MODE_ABS;
        offset_i <= off;
        wdata_i <= wd;
        seq[0] = `CBD_CODE_OPWR;
        seq[1] = `CBD_CODE_OPRD;
        run(2);
        chk(cap[0][27], 1'b1);
        chk(cap[0][23:8], off);
        chk(cap[0][7:0], wd);
        chk(rdata_o, wd);
        seq[0] = `CBD_CODE_PUSH;
        seq[1] = `CBD_CODE_PUSH;
        seq[2] = `CBD_CODE_POP;
        seq[3] = `CBD_CODE_POP;
        run(4);
        for (t = 0; t < 4; t++) begin
            chk(cap[t][23:8], (t == 1 || t == 2) ? 16'h00ff : 16'h0100);
            chk(cap[t][26:24], seq[t]);
        end
        chk(stack_pointer_o, 16'h0100);
        chk(rdata_o, wd);
        $display("test write push pop done");
        t = $random(seed);
        @(posedge clock_i);
        vec_low_i <= {t[7:1], 1'b0};
        seq[0] = `CBD_CODE_FREE;
        seq[1] = `CBD_CODE_VECT;
        seq[2] = `CBD_CODE_VECT;
        run(3);
        chk(cap[0][28:27], 2'h0);
        chk(cap[1][23:8], {8'hff, t[7:1], 1'b0});
        chk(cap[2][23:8], {8'hff, t[7:1], 1'b1});
        chk(program_counter_o, {pat({8'hff, t[7:1], 1'b0}), pat({8'hff, t[7:1], 1'b1})});
        $display("test vector done");
        @(posedge clock_i);
        offset_i <= 16'h2000;
        wdata_i <= `CBD_PAGE2_PREFIX;
        seq[0] = `CBD_CODE_OPWR;
        run(1);
        seq[0] = `CBD_CODE_PFETCH;
        seq[1] = `CBD_CODE_PFETCH;
        // first pass clears any prefix left over from earlier fetches
        for (t = 0; t < 3; t++) begin
            ld((t == 1) ? 16'h2000 : 16'h3000, ix, sp);
            run(2);
            chk(page2_o, t == 1);
        end
        $display("test page two done");
        fl = `CBD_RST_FLAGS;
        for (m = 0; m < 7; m++) begin
            t = $random(seed);
            act = (m == 0) ? 12'h555 : (m == 1) ? 12'haaa : (m == 2) ? 12'hfff : t[11:0];
            val = (m == 1) ? 6'h3f : t[17:12];
            @(posedge clock_i);
            flag_upd_i <= 1'b1;
            flag_act_i <= act;
            flag_val_i <= val;
            tick();
            fl = nf(fl, act, val);
            chk(condition_flags_reg_o, fl);
        end
        $display("test flags done");
        for (m = 0; m < 4; m++) begin
            pc = $random(seed);
            off = (m == 0) ? 16'h0080 : (m == 1) ? 16'h007f : $random(seed);
            ld(pc, ix, sp);
            branch_i <= 1'b1;
            offset_i <= off;
            tick();
            chk(program_counter_o, pc + {{8{off[7]}}, off[7:0]});
        end
        $display("test branch done");
        print_verdict();
    end
endmodule
